/* frame_parity.v */
// Odd parity helper for serial frames.
// Assumes a plain combinational use; no clock needed.
`timescale 1ns/1ns
module frame_parity #(
	parameter W = 16
) (
	input  wire [W-1:0] data_i,
	output wire         odd_o,
	output wire         fill_o
);

	// Odd count of ones, and the bit that would make it odd
	assign odd_o  = ^data_i;
	assign fill_o = ~(^data_i);

endmodule

/* host_link_model.sv */
// Host side of the serial link: sends frames on sdi and collects sdo.
// Assumes the bench calls xfer; all pins change on falling mclk edges.
`timescale 1ns/1ns
module host_link_model (
	input  wire mclk_i,
	input  wire sdo_i,
	output reg  strobe_n_o,
	output reg  sck_o,
	output reg  sdi_o
);
	// Idle pins at time zero
	initial begin
		strobe_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end

	// ----------------------------------------
	// One frame, MSB first, n bits long
	// ----------------------------------------
	task automatic xfer(input [15:1] w, input bit bad, input int n, output logic [15:0] r);
		logic [15:0] f;
		int          k;
		f = {w, (~^w) ^ bad};
		r = 16'h0000;
		strobe_n_o = 1'b0;
		repeat (2) @(negedge mclk_i);
		for (k = 15; k > 15 - n; k--) begin
			sdi_o = f[k];
			repeat (2) @(negedge mclk_i);
			sck_o = 1'b1;
			r[k] = sdo_i;
			repeat (2) @(negedge mclk_i);
			sck_o = 1'b0;
		end
		repeat (2) @(negedge mclk_i);
		strobe_n_o = 1'b1;
		sdi_o = ~sdi_o; // Released line shows no stale bit
		repeat (3) @(negedge mclk_i);
	endtask
endmodule

/* motor_driver_sys_cfg_diag_regs.v */
// Serial register bank: system configuration, save control, fault masks,
// verification, diagnostics and data acquisition readout.
// Assumes serial pins are synchronous to mclk_i and sck is slower than
// half the system clock, so every serial edge is seen.
//
// Overview of operation
// - Frames hold odd count of ones; bad parity frames are rejected.
// - Sleep entered only on sleep request 0 to 1 write, if enabled.
// - Logic regulator select: 0 is 3.3 V, 1 is 5 V, reset 0.
// - Gate regulator select: 0 is 8 V, 1 is 11 V, reset 1.
// - I/O regulator select: 0 is 3.3 V, 1 is 5 V, reset 0.
// - Bridge switch enable: 0 off, 1 active, reset 1.
// - Bus interface mode: 0 LIN, 1 PWM, reset LIN.
// - LIN rate select: 0 is 10 kHz, 1 is 20 kHz, reset 0.
// - LIN active: 0 standby, 1 active, reset standby.
// - Logic regulator disable: 1 switches off, reset 0 keeps on.
// - Save starts only when save code goes from 01 to 10.
// - Save copies the system configuration register only, excluding the sleep request bit.
// - Successful save rewrites save code to 01.
// - Failed save clears save code to 00.
// - Bridge mask: 1 disables fault detection; timeout mask resets set.
// - Supply mask: 1 disables fault detection; watchdog mask resets set.
// - Verification shows clock stopped, direction and gates off flags.
// - Phase monitor reads 1 high side active, 0 low side.
// - VDS diagnostic register shows six per-switch overvoltage faults.
// - Supply diagnostic shows undervoltages and three bootstrap bits.
// - Readout select picks temperature, bridge voltage or logic voltage.
`timescale 1ns/1ns
`include "motor_regs_defines.vh"
module motor_driver_sys_cfg_diag_regs #(
	parameter ADC_W = 10
) (
	input  wire             mclk_i,
	input  wire             srst_i,
	input  wire             strobe_n_i,
	input  wire             sck_i,
	input  wire             sdi_i,
	output wire             sdo_o,
	output wire             sdo_oe_o,
	input  wire             sleep_enable_i,
	output wire             sleep_enter_o,
	output wire             logic_reg_voltage_sel_o,
	output wire             gate_reg_voltage_sel_o,
	output wire             io_reg_voltage_sel_o,
	output wire             bridge_switch_enable_o,
	output wire             bus_interface_mode_o,
	output wire             lin_rate_sel_o,
	output wire             lin_active_o,
	output wire             logic_reg_disable_o,
	output wire [9:1]       fault_mask_bridge_o,
	output wire [9:1]       fault_mask_supply_o,
	output wire [9:1]       nvm_sys_cfg_o,
	output wire             nvm_start_o,
	input  wire             nvm_done_i,
	input  wire             nvm_pass_i,
	input  wire             clock_stopped_flag_i,
	input  wire             motor_direction_i,
	input  wire             gates_off_flag_i,
	input  wire             phase_a_side_monitor_i,
	input  wire             phase_b_side_monitor_i,
	input  wire             phase_c_side_monitor_i,
	input  wire [6:1]       vds_fault_flags_i,
	input  wire             battery_uv_i,
	input  wire             gate_reg_uv_i,
	input  wire             logic_reg_uv_i,
	input  wire             io_supply_uv_i,
	input  wire             bootstrap_uv_a_i,
	input  wire             bootstrap_uv_b_i,
	input  wire             bootstrap_uv_c_i,
	input  wire             overcurrent_fault_i,
	input  wire [1:0]       readout_select_i,
	input  wire [ADC_W-1:0] temp_code_i,
	input  wire [ADC_W-1:0] bridge_supply_code_i,
	input  wire [ADC_W-1:0] logic_reg_code_i
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg                     strobe_q;
	reg                     sck_q;
	reg  [`FRAME_BITS-1:0]  rx_q;
	reg  [`FRAME_BITS-1:0]  tx_q;
	reg  [`FRAME_CNT_W-1:0] cnt_q;
	reg  [4:0]              last_addr_q;
	reg  [9:1]              sys_cfg_q;
	reg  [9:1]              mask_bridge_q;
	reg  [9:1]              mask_supply_q;
	reg                     sleep_enter_q;
	reg                     por_q;
	reg                     xfer_err_q;
	reg                     nvm_err_q;
	reg  [9:0]              rd_data;
	reg  [9:0]              daq_value;
	wire                    frame_start;
	wire                    frame_end;
	wire                    sck_rise;
	wire                    sck_fall;
	wire                    selected;
	wire                    rx_odd;
	wire                    tx_fill;
	wire                    frame_good;
	wire                    frame_bad;
	wire                    wr_req;
	wire [4:0]              rx_addr;
	wire [9:1]              rx_data;
	wire [1:0]              save_code;
	wire                    save_fail;
	wire                    any_fault;
	wire [4:0]              status_bits;
	wire [14:0]             reply_body;

	// ----------------------------------------
	// Serial edge detection
	// ----------------------------------------
	// Previous pin levels for edge detection
	always @(posedge mclk_i) begin
		if (srst_i) begin
			strobe_q <= 1'b1;
			sck_q    <= 1'b0;
		end else begin
			strobe_q <= strobe_n_i;
			sck_q    <= sck_i;
		end
	end

	assign selected    = ~strobe_n_i;
	assign frame_start = strobe_q & ~strobe_n_i;
	assign frame_end   = ~strobe_q & strobe_n_i;
	assign sck_rise    = selected & sck_i & ~sck_q;
	assign sck_fall    = selected & ~sck_i & sck_q;

	// ----------------------------------------
	// Receive shifter and bit counter
	// ----------------------------------------
	// Sample on rising clock, most significant bit first
	always @(posedge mclk_i) begin
		if (srst_i) begin
			rx_q  <= {`FRAME_BITS{1'b0}};
			cnt_q <= {`FRAME_CNT_W{1'b0}};
		end else if (frame_start) begin
			cnt_q <= {`FRAME_CNT_W{1'b0}};
		end else if (sck_rise) begin
			rx_q <= {rx_q[`FRAME_BITS-2:0], sdi_i};
			if (cnt_q != `FRAME_CNT_MAX) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	frame_parity #(
		.W (`FRAME_BITS)
	) u_rx_parity (
		.data_i (rx_q),
		.odd_o  (rx_odd),
		.fill_o ()
	);

	assign frame_good = frame_end & rx_odd & (cnt_q == `FRAME_BITS);
	assign frame_bad  = frame_end & ~(rx_odd & (cnt_q == `FRAME_BITS));
	assign rx_addr    = rx_q[`ADDR_MSB:`ADDR_LSB];
	assign rx_data    = rx_q[`DATA_MSB:`DATA_LSB];
	assign wr_req     = frame_good & rx_q[`WR_BIT];

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	// decode writable numbers only
	always @(posedge mclk_i) begin
		if (srst_i) begin
			sys_cfg_q     <= `RST_SYS_CFG;
			mask_bridge_q <= `RST_MASK_BRIDGE;
			mask_supply_q <= `RST_MASK_SUPPLY;
		end else if (wr_req) begin
			if (rx_addr == `ADDR_SYS_CFG) begin
				sys_cfg_q <= rx_data;
			end else if (rx_addr == `ADDR_MASK_BRIDGE) begin
				mask_bridge_q <= rx_data;
			end else if (rx_addr == `ADDR_MASK_SUPPLY) begin
				mask_supply_q <= rx_data;
			end
		end
	end

	// Sleep request edge on a write
	always @(posedge mclk_i) begin
		if (srst_i) begin
			sleep_enter_q <= 1'b0;
		end else begin
			sleep_enter_q <= wr_req & (rx_addr == `ADDR_SYS_CFG) & sleep_enable_i
				& ~sys_cfg_q[`SYS_SLEEP_REQ] & rx_data[`SYS_SLEEP_REQ];
		end
	end

	// ----------------------------------------
	// Save sequencer
	// ----------------------------------------
	// Busy state stays inside; the host polls the save code
	nvm_save_seq u_save (
		.mclk_i      (mclk_i),
		.srst_i      (srst_i),
		.wr_en_i     (wr_req & (rx_addr == `ADDR_NVM_SAVE)),
		.wr_code_i   (rx_data[`SAVE_MSB:`SAVE_LSB]),
		.nvm_done_i  (nvm_done_i),
		.nvm_pass_i  (nvm_pass_i),
		.save_code_o (save_code),
		.nvm_start_o (nvm_start_o),
		.busy_o      (),
		.fail_o      (save_fail)
	);

	assign nvm_sys_cfg_o = {1'b0, sys_cfg_q[`SYS_SLEEP_REQ-1:`DATA_LSB]};

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Sticky flags; a set in the clearing cycle wins
	always @(posedge mclk_i) begin
		if (srst_i) begin
			por_q      <= 1'b1;
			xfer_err_q <= 1'b0;
			nvm_err_q  <= 1'b0;
		end else begin
			if (frame_start && last_addr_q == `ADDR_DAQ) begin
				por_q <= 1'b0;
			end
			if (frame_bad) begin
				xfer_err_q <= 1'b1;
			end else if (frame_start && last_addr_q == `ADDR_DAQ) begin
				xfer_err_q <= 1'b0;
			end
			if (save_fail) begin
				nvm_err_q <= 1'b1;
			end else if (frame_start && last_addr_q == `ADDR_DAQ) begin
				nvm_err_q <= 1'b0;
			end
		end
	end

	assign any_fault   = por_q | xfer_err_q | nvm_err_q | overcurrent_fault_i;
	assign status_bits = {any_fault, por_q, xfer_err_q, nvm_err_q, overcurrent_fault_i};

	// ----------------------------------------
	// Read data selection
	// ----------------------------------------
	// acquisition value select
	always @* begin
		daq_value = 10'h000;
		if (readout_select_i == `RBS_TEMP) begin
			daq_value = temp_code_i;
		end else if (readout_select_i == `RBS_BRIDGE_V) begin
			daq_value = bridge_supply_code_i;
		end else if (readout_select_i == `RBS_LOGIC_V) begin
			daq_value = logic_reg_code_i;
		end
	end

	// Data of the register addressed by the previous good frame
	always @* begin
		rd_data = 10'h000;
		if (last_addr_q == `ADDR_SYS_CFG) begin
			rd_data = {sys_cfg_q, 1'b0};
		end else if (last_addr_q == `ADDR_NVM_SAVE) begin
			rd_data = {save_code, 8'h00};
		end else if (last_addr_q == `ADDR_MASK_BRIDGE) begin
			rd_data = {mask_bridge_q, 1'b0};
		end else if (last_addr_q == `ADDR_MASK_SUPPLY) begin
			rd_data = {mask_supply_q, 1'b0};
		end else if (last_addr_q == `ADDR_VERIFY) begin
			rd_data = {3'h0, clock_stopped_flag_i, motor_direction_i, gates_off_flag_i,
				phase_c_side_monitor_i, phase_b_side_monitor_i, phase_a_side_monitor_i, 1'b0};
		end else if (last_addr_q == `ADDR_DIAG_VDS) begin
			rd_data = {3'h0, vds_fault_flags_i, 1'b0};
		end else if (last_addr_q == `ADDR_DIAG_SUPPLY) begin
			rd_data = {1'b0, battery_uv_i, gate_reg_uv_i, logic_reg_uv_i, io_supply_uv_i,
				1'b0, bootstrap_uv_c_i, bootstrap_uv_b_i, bootstrap_uv_a_i, 1'b0};
		end else if (last_addr_q == `ADDR_DAQ) begin
			rd_data = daq_value;
		end
	end

	assign reply_body = {status_bits, rd_data};

	frame_parity #(
		.W (`FRAME_BITS - 1)
	) u_tx_parity (
		.data_i (reply_body),
		.odd_o  (),
		.fill_o (tx_fill)
	);

	// ----------------------------------------
	// Transmit shifter and address pipe
	// ----------------------------------------
	// Load at frame start, shift on falling clock
	always @(posedge mclk_i) begin
		if (srst_i) begin
			tx_q        <= {`FRAME_BITS{1'b0}};
			last_addr_q <= `ADDR_DAQ;
		end else begin
			if (frame_start) begin
				tx_q <= {reply_body, tx_fill};
			end else if (sck_fall) begin
				tx_q <= {tx_q[`FRAME_BITS-2:0], 1'b0};
			end
			if (frame_good) begin
				last_addr_q <= rx_addr;
			end
		end
	end

	assign sdo_o    = tx_q[`FRAME_BITS-1];
	assign sdo_oe_o = selected;

	// ----------------------------------------
	// Configuration outputs
	// ----------------------------------------
	// sleep pulse out
	assign sleep_enter_o           = sleep_enter_q;
	assign logic_reg_voltage_sel_o = sys_cfg_q[`SYS_LOGIC_VSEL];
	assign gate_reg_voltage_sel_o  = sys_cfg_q[`SYS_GATE_VSEL];
	assign io_reg_voltage_sel_o    = sys_cfg_q[`SYS_IO_VSEL];
	assign bridge_switch_enable_o  = sys_cfg_q[`SYS_BRIDGE_EN];
	assign bus_interface_mode_o    = sys_cfg_q[`SYS_BUS_MODE];
	assign lin_rate_sel_o          = sys_cfg_q[`SYS_LIN_RATE];
	assign lin_active_o            = sys_cfg_q[`SYS_LIN_ACTIVE];
	assign logic_reg_disable_o     = sys_cfg_q[`SYS_LOGIC_DIS];
	assign fault_mask_bridge_o     = mask_bridge_q;
	assign fault_mask_supply_o     = mask_supply_q;

endmodule

/* motor_driver_sys_cfg_diag_regs_bench.sv */
// Self-checking bench for the serial register bank.
// Assumes the host link model and checker files are compiled with it.
`timescale 1ns/1ns
`include "motor_regs_defines.vh"
module motor_driver_sys_cfg_diag_regs_bench;
	reg          mclk_i = 1'b0;
	reg          srst_i = 1'b1;
	reg          sleep_en = 1'b1;
	reg          done = 1'b0;
	reg          pass = 1'b0;
	reg  [6:1]   vf = 6'h00;
	reg  [6:1]   vds = 6'h00;
	reg  [8:1]   uv = 8'h00;
	reg          oc = 1'b0;
	reg  [1:0]   sel = 2'h0;
	reg  [9:0]   tc = 10'h2a5;
	reg  [9:0]   bc = 10'h15a;
	reg  [9:0]   lc = 10'h3c3;
	wire         strobe_n;
	wire         sck;
	wire         sdi;
	wire         sdo;
	wire         oe;
	wire         sleep_p;
	wire         start_p;
	wire [8:1]   cfg;
	wire [9:1]   mb;
	wire [9:1]   ms;
	int          n_errors = 0;
	int          comparisons = 0;
	int          n_sleep = 0;
	int          n_start = 0;
	int          cycles = 0;
	int          n_oe = 0;
	logic [15:0] r;

	motor_driver_sys_cfg_diag_regs #(.ADC_W(10)) motor_driver_sys_cfg_diag_regs_i (
		.mclk_i(mclk_i), .srst_i(srst_i), .strobe_n_i(strobe_n), .sck_i(sck), .sdi_i(sdi), .sdo_o(sdo),
		.sdo_oe_o(oe), .sleep_enable_i(sleep_en), .sleep_enter_o(sleep_p), .logic_reg_voltage_sel_o(cfg[8]),
		.gate_reg_voltage_sel_o(cfg[7]), .io_reg_voltage_sel_o(cfg[6]), .bridge_switch_enable_o(cfg[5]),
		.bus_interface_mode_o(cfg[4]), .lin_rate_sel_o(cfg[3]), .lin_active_o(cfg[2]),
		.logic_reg_disable_o(cfg[1]), .fault_mask_bridge_o(mb), .fault_mask_supply_o(ms), .nvm_sys_cfg_o(),
		.nvm_start_o(start_p), .nvm_done_i(done), .nvm_pass_i(pass), .clock_stopped_flag_i(vf[6]),
		.motor_direction_i(vf[5]), .gates_off_flag_i(vf[4]), .phase_c_side_monitor_i(vf[3]),
		.phase_b_side_monitor_i(vf[2]), .phase_a_side_monitor_i(vf[1]), .vds_fault_flags_i(vds),
		.battery_uv_i(uv[8]), .gate_reg_uv_i(uv[7]), .logic_reg_uv_i(uv[6]), .io_supply_uv_i(uv[5]),
		.bootstrap_uv_c_i(uv[3]), .bootstrap_uv_b_i(uv[2]), .bootstrap_uv_a_i(uv[1]),
		.overcurrent_fault_i(oc), .readout_select_i(sel), .temp_code_i(tc), .bridge_supply_code_i(bc),
		.logic_reg_code_i(lc)
	);
	host_link_model host_link_model_i (.mclk_i(mclk_i), .sdo_i(sdo), .strobe_n_o(strobe_n), .sck_o(sck), .sdi_o(sdi));

	// ----------------------------------------
	// Clock, pulse counters, hang guard
	// ----------------------------------------
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles++;
		n_sleep += sleep_p;
		n_start += start_p;
		n_oe += (oe !== ~strobe_n);
		if (cycles == 20000) begin
			n_errors++;
			close_out();
		end
	end

	task automatic check(input logic [15:0] s, input logic [15:0] e, input string m);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic fr(input [15:1] w);
		host_link_model_i.xfer(w, 1'b0, 16, r);
	endtask
	task automatic wr(input [4:0] a, input [8:0] d);
		fr({a, 1'b1, d});
	endtask
	// Reply is pipelined: second frame returns the addressed register
	task automatic rd(input [4:0] a);
		fr({a, 10'h000});
		fr({a, 10'h000});
		check(^r, 1'b1, "reply parity");
	endtask

	task automatic t_reset;
		check(cfg, 8'h50, "cfg default");
		check(mb, 9'h100, "mask0 default");
		check(ms, 9'h008, "mask1 default");
		fr({`ADDR_SYS_CFG, 10'h000});
		check(r[15:14], 2'h3, "power-on flags");
		check(r[10:1], tc, "first readout");
	endtask
	task automatic t_syscfg;
		wr(`ADDR_SYS_CFG, 9'h0aa);
		check(cfg, 8'haa, "cfg write a");
		wr(`ADDR_SYS_CFG, 9'h155);
		check(cfg, 8'h55, "cfg write b");
		check(n_sleep[15:0], 16'h0001, "sleep on rise");
		wr(`ADDR_SYS_CFG, 9'h155);
		wr(`ADDR_SYS_CFG, 9'h055);
		sleep_en = 1'b0;
		wr(`ADDR_SYS_CFG, 9'h155);
		sleep_en = 1'b1;
		check(n_sleep[15:0], 16'h0001, "no sleep on hold, fall or disabled");
		rd(`ADDR_SYS_CFG);
		check(r[10:2], 9'h155, "cfg readback");
	endtask
	task automatic t_masks;
		wr(`ADDR_MASK_BRIDGE, 9'h13f);
		wr(`ADDR_MASK_SUPPLY, 9'h0f0);
		check({mb, ms}, {9'h13f, 9'h0f0}, "masks a");
		rd(`ADDR_MASK_BRIDGE);
		check(r[10:2], 9'h13f, "mask0 readback");
		wr(`ADDR_MASK_BRIDGE, 9'h080);
		wr(`ADDR_MASK_SUPPLY, 9'h00f);
		check({mb, ms}, {9'h080, 9'h00f}, "masks b");
		rd(`ADDR_MASK_SUPPLY);
		check(r[10:2], 9'h00f, "mask1 readback");
	endtask
	task automatic t_readonly;
		vf = 6'h2b;
		vds = 6'h15;
		uv = 8'hb5;
		oc = 1'b1;
		wr(`ADDR_VERIFY, 9'h1ff);
		wr(5'h19, 9'h1ff);
		wr(`ADDR_DAQ, 9'h1ff);
		check({cfg, mb}, {8'h55, 9'h080}, "write ignored");
		rd(`ADDR_VERIFY);
		check(r[11:2], {1'b1, 3'h0, vf}, "verify a");
		vf = 6'h14;
		rd(`ADDR_VERIFY);
		check(r[10:2], {3'h0, vf}, "verify b");
		rd(`ADDR_DIAG_VDS);
		check(r[10:2], {3'h0, vds}, "vds diag");
		rd(`ADDR_DIAG_SUPPLY);
		check(r[10:2], {1'b0, uv}, "supply diag");
		oc = 1'b0;
	endtask
	task automatic t_daq;
		int s;
		for (s = 0; s < 4; s++) begin
			sel = s[1:0];
			fr({`ADDR_DAQ, 1'b0, 9'h1ff});
			fr({`ADDR_DAQ, 1'b0, 9'h1ff});
			check(r[15:1], {5'h00, (s == 0) ? tc : (s == 1) ? bc : (s == 2) ? lc : 10'h000}, "readout");
		end
		sel = 2'h0;
	endtask
	task automatic t_errors;
		host_link_model_i.xfer({`ADDR_SYS_CFG, 1'b1, 9'h0aa}, 1'b1, 16, r);
		check(cfg, 8'h55, "bad parity ignored");
		host_link_model_i.xfer({`ADDR_SYS_CFG, 1'b1, 9'h0aa}, 1'b0, 15, r);
		check(cfg, 8'h55, "short frame ignored");
		fr({`ADDR_DAQ, 10'h000});
		check({r[15], r[13]}, 2'h3, "transfer error flag");
		check(n_oe[15:0], 16'h0000, "output enable outside frame");
	endtask
	task automatic t_save;
		int p;
		wr(`ADDR_NVM_SAVE, {`SAVE_GO, 7'h00});
		check(n_start[15:0], 16'h0000, "no save without arm");
		for (p = 1; p >= 0; p--) begin
			wr(`ADDR_NVM_SAVE, {`SAVE_ARM, 7'h00});
			wr(`ADDR_NVM_SAVE, {`SAVE_GO, 7'h00});
			check(n_start[15:0], 16'h0002 - p[15:0], "save start");
			pass = p[0];
			done = 1'b1;
			@(negedge mclk_i);
			done = 1'b0;
			rd(`ADDR_NVM_SAVE);
			check(r[12:9], {~p[0], 1'b0, 1'b0, p[0]}, "save result");
		end
	endtask

	task close_out;
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Reset, then the scenarios in turn
	initial begin
		repeat (3) @(negedge mclk_i);
		srst_i = 1'b0;
		@(negedge mclk_i);
		t_reset();
		t_syscfg();
		t_masks();
		t_readonly();
		t_daq();
		t_errors();
		t_save();
		close_out();
	end
endmodule

/* motor_regs_defines.vh */
// Constants shared by the serial register bank and its helpers.
// Assumes it is included by bare name in each design file that needs it.
`ifndef MOTOR_REGS_DEFINES_VH
`define MOTOR_REGS_DEFINES_VH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define FRAME_BITS        16
`define FRAME_CNT_W       5
`define FRAME_CNT_MAX     5'h1F
`define ADDR_MSB          15
`define ADDR_LSB          11
`define WR_BIT            10
`define DATA_MSB          9
`define DATA_LSB          1

// ----------------------------------------
// Register numbers
// ----------------------------------------
`define ADDR_SYS_CFG      5'h17
`define ADDR_NVM_SAVE     5'h18
`define ADDR_MASK_BRIDGE  5'h1A
`define ADDR_MASK_SUPPLY  5'h1B
`define ADDR_VERIFY       5'h1C
`define ADDR_DIAG_VDS     5'h1D
`define ADDR_DIAG_SUPPLY  5'h1E
`define ADDR_DAQ          5'h1F

// ----------------------------------------
// Power-on values of data bits 9..1
// ----------------------------------------
`define RST_SYS_CFG       9'h0_50
`define RST_MASK_BRIDGE   9'h1_00
`define RST_MASK_SUPPLY   9'h0_08

// ----------------------------------------
// System configuration bit positions
// ----------------------------------------
`define SYS_SLEEP_REQ     9
`define SYS_LOGIC_VSEL    8
`define SYS_GATE_VSEL     7
`define SYS_IO_VSEL       6
`define SYS_BRIDGE_EN     5
`define SYS_BUS_MODE      4
`define SYS_LIN_RATE      3
`define SYS_LIN_ACTIVE    2
`define SYS_LOGIC_DIS     1

// ----------------------------------------
// Save code and readout select values
// ----------------------------------------
`define SAVE_MSB          9
`define SAVE_LSB          8
`define SAVE_IDLE         2'h0
`define SAVE_ARM          2'h1
`define SAVE_GO           2'h2
`define RBS_TEMP          2'h0
`define RBS_BRIDGE_V      2'h1
`define RBS_LOGIC_V       2'h2

`endif

/* motor_regs_props.sv */
// Assertions on the register bank's pulses and configuration outputs.
// Assumes the bind below; sees only ports of the top module.
`timescale 1ns/1ns
module motor_regs_props (
	input wire       mclk_i,
	input wire       srst_i,
	input wire       strobe_n_i,
	input wire       sleep_enable_i,
	input wire       sleep_enter_o,
	input wire       logic_reg_voltage_sel_o,
	input wire       gate_reg_voltage_sel_o,
	input wire       io_reg_voltage_sel_o,
	input wire       bridge_switch_enable_o,
	input wire       bus_interface_mode_o,
	input wire       lin_rate_sel_o,
	input wire       lin_active_o,
	input wire       logic_reg_disable_o,
	input wire [9:1] fault_mask_bridge_o,
	input wire [9:1] fault_mask_supply_o,
	input wire [9:1] nvm_sys_cfg_o,
	input wire       nvm_start_o
);
	// Configuration bits 8..1 gathered
	wire [8:1] cfg_w;
	assign cfg_w = {logic_reg_voltage_sel_o, gate_reg_voltage_sel_o, io_reg_voltage_sel_o, bridge_switch_enable_o,
		bus_interface_mode_o, lin_rate_sel_o, lin_active_o, logic_reg_disable_o};

	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	// Strobe rose one or two cycles back
	sequence closed_s;
		($past(strobe_n_i) && !$past(strobe_n_i, 2)) || ($past(strobe_n_i, 2) && !$past(strobe_n_i, 3));
	endsequence
	// No pulse this cycle
	sequence quiet_s;
		!sleep_enter_o && !nvm_start_o;
	endsequence

	cfg_reset_a: assert property (disable iff (1'b0) srst_i |=> cfg_w == 8'h50)
		else $error("config outputs not at power-on values");
	mask_reset_a: assert property (disable iff (1'b0) srst_i |=>
		fault_mask_bridge_o == 9'h100 && fault_mask_supply_o == 9'h008)
		else $error("mask outputs not at power-on values");
	sleep_cause_a: assert property (sleep_enter_o |-> closed_s)
		else $error("sleep pulse without a closed frame");
	sleep_gate_a: assert property (sleep_enter_o |-> $past(sleep_enable_i))
		else $error("sleep pulse while sleep disabled");
	start_cause_a: assert property (nvm_start_o |-> closed_s)
		else $error("save start without a closed frame");
	pulse_once_a: assert property ((sleep_enter_o || nvm_start_o) |=> quiet_s)
		else $error("pulse longer than one cycle");
	cfg_write_a: assert property (!$stable({cfg_w, fault_mask_bridge_o, fault_mask_supply_o}) |-> closed_s)
		else $error("register changed outside a frame end");
	save_image_a: assert property (nvm_sys_cfg_o == {1'b0, cfg_w})
		else $error("save image differs from configuration");
endmodule

bind motor_driver_sys_cfg_diag_regs motor_regs_props motor_regs_props_i (
	.mclk_i, .srst_i, .strobe_n_i, .sleep_enable_i, .sleep_enter_o, .logic_reg_voltage_sel_o,
	.gate_reg_voltage_sel_o, .io_reg_voltage_sel_o, .bridge_switch_enable_o, .bus_interface_mode_o,
	.lin_rate_sel_o, .lin_active_o, .logic_reg_disable_o, .fault_mask_bridge_o, .fault_mask_supply_o,
	.nvm_sys_cfg_o, .nvm_start_o
);

/* nvm_save_seq.v */
// Save code register and non-volatile save sequencer.
// Assumes the NVM controller answers each start with one done pulse.
`timescale 1ns/1ns
`include "motor_regs_defines.vh"
module nvm_save_seq (
	input  wire       mclk_i,
	input  wire       srst_i,
	input  wire       wr_en_i,
	input  wire [1:0] wr_code_i,
	input  wire       nvm_done_i,
	input  wire       nvm_pass_i,
	output wire [1:0] save_code_o,
	output wire       nvm_start_o,
	output wire       busy_o,
	output wire       fail_o
);

	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;

	reg       state_q;
	reg [1:0] code_q;
	reg       start_q;
	reg       fail_q;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Writes are ignored while a save runs
	always @(posedge mclk_i) begin
		if (srst_i) begin
			state_q <= ST_IDLE;
			code_q  <= `SAVE_IDLE;
			start_q <= 1'b0;
			fail_q  <= 1'b0;
		end else begin
			start_q <= 1'b0;
			fail_q  <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (wr_en_i) begin
						code_q <= wr_code_i;
						if (code_q == `SAVE_ARM && wr_code_i == `SAVE_GO) begin
							start_q <= 1'b1;
							state_q <= ST_BUSY;
						end
					end
				end
				ST_BUSY: begin
					if (nvm_done_i) begin
						state_q <= ST_IDLE;
						if (nvm_pass_i) begin
							code_q <= `SAVE_ARM;
						end else begin
							code_q <= `SAVE_IDLE;
							fail_q <= 1'b1;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign save_code_o = code_q;
	assign nvm_start_o = start_q;
	assign busy_o      = state_q;
	assign fail_o      = fail_q;

endmodule
